// File: rtl/esc_pkg.sv
// Purpose: constants and types for the static memory controller
// Assumes: one system clock, AHB-Lite register and memory port
// Notes: config registers sit outside the 010 memory region
//
// What this block does
// - eight banks, own setup, 16 MB each
// - serves RAM, ROM, flash, burst ROM, I/O
// - per-bank data width 8, 16 or 32
// - one to 16 programmable idle cycles
// - separate read and write waits, up to 31
// - burst ROM: initial and subsequent wait counts
// - page-mode reads without a memory clock
// - burst reads enabled per bank
// - write-protected bank gets no write cycle
// - per-bank byte lane control on reads
// - one chip select per bank, polarity set
// - address bits 28..26 pick the bank
// - address bits 25..24 ignored, aliasing
// - address bits 23..2 drive the address bus, bits 1..0 only on 32-bit banks
// - active-low write strobe on writes
// - active-low output enable on reads
// - four byte lane strobes, lanes 0 to 3
// - 32-bit two-way data bus, driven on writes
// - idle cycles between read and later write
package esc_pkg;

	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [2:0] EXT_REGION = 3'h2;
	localparam int REGION_MSB = 31;
	localparam int REGION_LSB = 29;
	localparam int BANK_MSB = 28;
	localparam int BANK_LSB = 26;
	localparam int OFFS_MSB = 23;
	localparam int NUM_BANKS = 8;
	localparam int ADDR_W = 24;
	// register offsets: cfg_a at bank*8, cfg_b at bank*8+4
	localparam logic [11:0] STATUS_OFFS = 12'h040;
	localparam logic [5:0] CFG_HIGH_ZERO = 6'h00;
	// status fields
	localparam int STAT_PROT = 0;
	localparam int STAT_IDLE = 1;

	// ----------------------------------------
	// bank configuration
	// ----------------------------------------
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	typedef enum logic [2:0] {
		MEM_SRAM, MEM_ROM, MEM_FLASH, MEM_BURST_ROM, MEM_IO
	} esc_mem_type_t;

	// cfg_a register layout, lsb is width
	typedef struct packed {
		esc_mem_type_t mem_type;
		logic cs_high;
		logic rd_lanes;
		logic burst_en;
		logic wr_protect;
		logic [3:0] turn;
		logic [4:0] wr_wait;
		logic [4:0] rd_wait;
		logic [1:0] width;
	} esc_bank_cfg_t;

	// cfg_b register layout
	typedef struct packed {
		logic [4:0] seq_wait;
		logic [4:0] init_wait;
	} esc_burst_cfg_t;

	// slowest read timing and turnaround, write wait 30, full width, sram, active-low select
	localparam logic [22:0] CFG_A_RESET = 23'h00ff7e;
	localparam logic [9:0] CFG_B_RESET = 10'h3ff;

	// latched address phase
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic [2:0] size;
	} esc_ahb_req_t;

endpackage

// File: rtl/esc_static_mem.sv
// Purpose: AHB-Lite slave driving an external static memory bus
// Assumes: single whole-word master, ext_data_in synchronous
// Notes: every output comes from a flip-flop
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module esc_static_mem #(
	parameter int PAGE_BITS = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [7:0] bank_select_out,
	output logic [3:0] byte_lane_strobe_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [23:0] ext_address_bus,
	output logic [31:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [31:0] ext_data_in
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// index of the last beat for a bank width
	function automatic logic [1:0] last_beat(input logic [1:0] w);
		unique case (w)
			esc_pkg::WIDTH_8: last_beat = 2'h3;
			esc_pkg::WIDTH_16: last_beat = 2'h1;
			default: last_beat = 2'h0;
		endcase
	endfunction

	// bit offset of a beat inside the word
	function automatic logic [4:0] beat_shift(input logic [1:0] w, input logic [1:0] b);
		unique case (w)
			esc_pkg::WIDTH_8: beat_shift = {b, 3'h0};
			esc_pkg::WIDTH_16: beat_shift = {b[0], 4'h0};
			default: beat_shift = 5'h00;
		endcase
	endfunction

	// byte lanes touched by a full-width access
	function automatic logic [3:0] size_lanes(input logic [2:0] s, input logic [1:0] a);
		unique case (s)
			3'h0: size_lanes = 4'h1 << a;
			3'h1: size_lanes = a[1] ? 4'hc : 4'h3;
			default: size_lanes = 4'hf;
		endcase
	endfunction

	// data bits valid on the bus for a width
	function automatic logic [31:0] width_mask(input logic [1:0] w);
		unique case (w)
			esc_pkg::WIDTH_8: width_mask = 32'h0000_00ff;
			esc_pkg::WIDTH_16: width_mask = 32'h0000_ffff;
			default: width_mask = 32'hffff_ffff;
		endcase
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE} esc_state_t;

	esc_state_t state, next_state;
	esc_pkg::esc_ahb_req_t req, next_req; // held address phase
	logic reg_wr_pend, next_reg_wr_pend; // register write in data phase
	esc_pkg::esc_bank_cfg_t cfg_a [esc_pkg::NUM_BANKS];
	esc_pkg::esc_bank_cfg_t next_cfg_a [esc_pkg::NUM_BANKS];
	esc_pkg::esc_burst_cfg_t cfg_b [esc_pkg::NUM_BANKS];
	esc_pkg::esc_burst_cfg_t next_cfg_b [esc_pkg::NUM_BANKS];
	logic prot_hit, next_prot_hit; // sticky: write hit protected bank
	logic [31:0] wdata, next_wdata; // write word held over beats
	logic [31:0] rdata_acc, next_rdata_acc; // read word being assembled
	logic [1:0] beat, next_beat;
	logic [4:0] wait_cnt, next_wait_cnt; // strobe cycles left
	logic [4:0] idle_cnt, next_idle_cnt; // turnaround cycles left
	logic [2:0] last_bank, next_last_bank;
	logic [esc_pkg::ADDR_W-1-PAGE_BITS:0] last_page, next_last_page;
	logic page_valid, next_page_valid; // open page for burst reads
	logic next_hreadyout;
	logic [31:0] next_hrdata;
	logic [7:0] next_bank_select_out;
	logic [3:0] next_byte_lane_strobe_n;
	logic next_write_strobe_n;
	logic next_read_strobe_n;
	logic [23:0] next_ext_address_bus;
	logic [31:0] next_ext_data_out;
	logic next_ext_data_oe;

	// decoded view of the held request
	logic [2:0] bank;
	esc_pkg::esc_bank_cfg_t cur;
	esc_pkg::esc_burst_cfg_t curb;
	logic [4:0] shift;
	logic [3:0] lanes;
	logic [31:0] wsrc;
	logic seq_read;
	logic accept;
	logic ext_hit;
	logic [31:0] reg_rdata;
	logic [7:0] idle_sel; // inactive level of every bank select

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// bank comes from bits 28..26 only; 25..24 never looked at
	always_comb begin
		bank = req.addr[esc_pkg::BANK_MSB:esc_pkg::BANK_LSB];
		cur = cfg_a[bank];
		curb = cfg_b[bank];
		shift = beat_shift(cur.width, beat);
		wsrc = (beat == 2'h0) ? hwdata : wdata;
		// narrow banks carry lane 0 or lanes 0..1 per beat
		if (cur.width == esc_pkg::WIDTH_32) begin
			lanes = size_lanes(req.size, req.addr[1:0]);
		end else if (cur.width == esc_pkg::WIDTH_16) begin
			lanes = 4'h3;
		end else begin
			lanes = 4'h1;
		end
		// later beat, or same open page of the same bank
		seq_read = cur.burst_en && !req.write &&
			(beat != 2'h0 || (page_valid && bank == last_bank &&
			last_page == req.addr[esc_pkg::OFFS_MSB:PAGE_BITS]));
		accept = hsel && htrans[1] && hready;
		ext_hit = haddr[esc_pkg::REGION_MSB:esc_pkg::REGION_LSB] == esc_pkg::EXT_REGION;
		// each line idles at its own bank's inactive level, not the current bank's
		for (int i = 0; i < esc_pkg::NUM_BANKS; i++) begin
			idle_sel[i] = !cfg_a[i].cs_high;
		end
	end

	// register read value, taken in the address phase
	always_comb begin
		reg_rdata = 32'h0000_0000;
		if (haddr[11:6] == esc_pkg::CFG_HIGH_ZERO) begin
			if (haddr[2]) begin
				reg_rdata = {22'h0, cfg_b[haddr[5:3]]};
			end else begin
				reg_rdata = {9'h0, cfg_a[haddr[5:3]]};
			end
		end else if (haddr[11:0] == esc_pkg::STATUS_OFFS) begin
			reg_rdata[esc_pkg::STAT_PROT] = prot_hit;
			reg_rdata[esc_pkg::STAT_IDLE] = idle_cnt != 5'h00;
			reg_rdata[4:2] = last_bank;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_req = req;
		next_reg_wr_pend = 1'b0;
		next_cfg_a = cfg_a;
		next_cfg_b = cfg_b;
		next_prot_hit = prot_hit;
		next_wdata = wdata;
		next_rdata_acc = rdata_acc;
		next_beat = beat;
		next_wait_cnt = wait_cnt;
		next_idle_cnt = idle_cnt;
		next_last_bank = last_bank;
		next_last_page = last_page;
		next_page_valid = page_valid;
		next_hreadyout = hreadyout;
		next_hrdata = hrdata;
		next_bank_select_out = (state == ST_STROBE) ? bank_select_out : idle_sel;
		next_byte_lane_strobe_n = byte_lane_strobe_n;
		next_write_strobe_n = write_strobe_n;
		next_read_strobe_n = read_strobe_n;
		next_ext_address_bus = ext_address_bus;
		next_ext_data_out = ext_data_out;
		next_ext_data_oe = ext_data_oe;

		// turnaround runs down whatever the state
		if (idle_cnt != 5'h00) begin
			next_idle_cnt = idle_cnt - 5'h01;
		end

		// register write lands in its data phase
		if (reg_wr_pend) begin
			if (req.addr[11:6] == esc_pkg::CFG_HIGH_ZERO) begin
				if (req.addr[2]) begin
					next_cfg_b[req.addr[5:3]] = esc_pkg::esc_burst_cfg_t'(hwdata[9:0]);
				end else begin
					next_cfg_a[req.addr[5:3]] = esc_pkg::esc_bank_cfg_t'(hwdata[22:0]);
				end
			end else if (req.addr[11:0] == esc_pkg::STATUS_OFFS) begin
				// write one clears; a set below still wins
				if (hwdata[esc_pkg::STAT_PROT]) begin
					next_prot_hit = 1'b0;
				end
			end
		end

		unique case (state)
			// wait for an address phase
			ST_IDLE: begin
				if (accept) begin
					next_req = '{addr: haddr, write: hwrite, size: hsize};
					if (ext_hit) begin
						// stall from the first data-phase cycle
						next_state = ST_SETUP;
						next_hreadyout = 1'b0;
						next_beat = 2'h0;
						next_rdata_acc = 32'h0000_0000;
					end else if (hwrite) begin
						next_reg_wr_pend = 1'b1;
					end else begin
						next_hrdata = reg_rdata;
					end
				end
			end

			// start a beat once turnaround allows
			ST_SETUP: begin
				if (beat == 2'h0) begin
					next_wdata = hwdata;
				end
				if (req.write && (cur.wr_protect || cur.mem_type == esc_pkg::MEM_ROM ||
					cur.mem_type == esc_pkg::MEM_BURST_ROM)) begin
					// finish on the bus, nothing reaches the pins
					next_prot_hit = 1'b1;
					next_hreadyout = 1'b1;
					next_state = ST_IDLE;
				end else if (idle_cnt != 5'h00 && (req.write || bank != last_bank)) begin
					// hold off: the last read may still drive the bus
					next_state = ST_SETUP;
				end else begin
					if (cur.width == esc_pkg::WIDTH_32) begin
						next_ext_address_bus = req.addr[esc_pkg::OFFS_MSB:0];
					end else begin
						next_ext_address_bus = {req.addr[esc_pkg::OFFS_MSB:2], shift[4:3]};
					end
					next_bank_select_out[bank] = cur.cs_high;
					if (req.write) begin
						next_write_strobe_n = 1'b0;
						next_ext_data_out = wsrc >> shift;
						next_ext_data_oe = 1'b1;
						next_byte_lane_strobe_n = ~lanes;
						next_wait_cnt = cur.wr_wait;
					end else begin
						next_read_strobe_n = 1'b0;
						// lanes may stay idle on reads for 8-bit parts
						next_byte_lane_strobe_n = cur.rd_lanes ? ~lanes : 4'hf;
						if (seq_read) begin
							next_wait_cnt = curb.seq_wait;
						end else if (cur.burst_en) begin
							next_wait_cnt = curb.init_wait;
						end else begin
							next_wait_cnt = cur.rd_wait;
						end
					end
					next_state = ST_STROBE;
				end
			end

			// strobe held for the wait count plus one
			ST_STROBE: begin
				if (wait_cnt != 5'h00) begin
					next_wait_cnt = wait_cnt - 5'h01;
				end else begin
					next_write_strobe_n = 1'b1;
					next_read_strobe_n = 1'b1;
					next_ext_data_oe = 1'b0;
					next_byte_lane_strobe_n = 4'hf;
					next_bank_select_out = idle_sel;
					if (!req.write) begin
						next_rdata_acc = rdata_acc | ((ext_data_in & width_mask(cur.width)) << shift);
					end
					if (beat == last_beat(cur.width)) begin
						next_state = ST_IDLE;
						next_hreadyout = 1'b1;
						next_last_bank = bank;
						if (req.write) begin
							next_page_valid = 1'b0;
						end else begin
							next_hrdata = rdata_acc | ((ext_data_in & width_mask(cur.width)) << shift);
							next_idle_cnt = {1'b0, cur.turn} + 5'h01;
							next_page_valid = cur.burst_en;
							next_last_page = req.addr[esc_pkg::OFFS_MSB:PAGE_BITS];
						end
					end else begin
						next_beat = beat + 2'h1;
						next_state = ST_SETUP;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// constants only under reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			req <= '0;
			reg_wr_pend <= 1'b0;
			for (int i = 0; i < esc_pkg::NUM_BANKS; i++) begin
				cfg_a[i] <= esc_pkg::esc_bank_cfg_t'(esc_pkg::CFG_A_RESET);
				cfg_b[i] <= esc_pkg::esc_burst_cfg_t'(esc_pkg::CFG_B_RESET);
			end
			prot_hit <= 1'b0;
			wdata <= 32'h0000_0000;
			rdata_acc <= 32'h0000_0000;
			beat <= 2'h0;
			wait_cnt <= 5'h00;
			idle_cnt <= 5'h00;
			last_bank <= 3'h0;
			last_page <= '0;
			page_valid <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
			bank_select_out <= 8'hff;
			byte_lane_strobe_n <= 4'hf;
			write_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			ext_address_bus <= 24'h00_0000;
			ext_data_out <= 32'h0000_0000;
			ext_data_oe <= 1'b0;
		end else begin
			state <= next_state;
			req <= next_req;
			reg_wr_pend <= next_reg_wr_pend;
			cfg_a <= next_cfg_a;
			cfg_b <= next_cfg_b;
			prot_hit <= next_prot_hit;
			wdata <= next_wdata;
			rdata_acc <= next_rdata_acc;
			beat <= next_beat;
			wait_cnt <= next_wait_cnt;
			idle_cnt <= next_idle_cnt;
			last_bank <= next_last_bank;
			last_page <= next_last_page;
			page_valid <= next_page_valid;
			hreadyout <= next_hreadyout;
			hrdata <= next_hrdata;
			// every answer is OKAY
			hresp <= 1'b0;
			bank_select_out <= next_bank_select_out;
			byte_lane_strobe_n <= next_byte_lane_strobe_n;
			write_strobe_n <= next_write_strobe_n;
			read_strobe_n <= next_read_strobe_n;
			ext_address_bus <= next_ext_address_bus;
			ext_data_out <= next_ext_data_out;
			ext_data_oe <= next_ext_data_oe;
		end
	end

endmodule

// File: test/esc_sram_model.sv
// Purpose: behavioural static memory on the external bus
// Assumes: cs_pol gives the active level of each bank select
// Notes: reports strobe lengths and gaps for the bench
`timescale 1ns/1ps
module esc_sram_model (
	input wire logic hclk,
	input wire logic [7:0] cs_pol,
	input wire logic [7:0] bank_select_out,
	input wire logic [3:0] byte_lane_strobe_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [23:0] ext_address_bus,
	input wire logic [31:0] ext_data_out,
	input wire logic ext_data_oe,
	output logic [31:0] ext_data_in,
	output int bank,
	output int wr_len,
	output int rd_len,
	output int gap,
	output int wbeats,
	output logic [3:0] rd_lanes
);
	logic [31:0] mem [int]; // word store keyed by bank and word
	logic [31:0] last = 32'h0; // last value put on the bus
	logic [31:0] tmp;
	int act, key, k, j, wcnt = 0, rcnt = 0, idle = 0;
	// decode the selected bank, answer reads at once
	always @* begin
		act = -1;
		for (k = 0; k < 8; k++) if (bank_select_out[k] === cs_pol[k]) act = k;
		key = act * 32'h400000 + int'(ext_address_bus[23:2]);
		// off-bus the line shows the inverse, never a stale match
		if (!read_strobe_n && act >= 0) ext_data_in = mem.exists(key) ? mem[key] : 32'h0;
		else ext_data_in = ~last;
	end
	// take write data, measure strobes and gaps
	always @(posedge hclk) begin
		if (!read_strobe_n && act >= 0) last <= ext_data_in;
		if (!write_strobe_n && act >= 0) begin
			tmp = mem.exists(key) ? mem[key] : 32'h0;
			// undriven data is stored as unknown so it cannot pass
			for (j = 0; j < 4; j++) if (!byte_lane_strobe_n[j]) tmp[8*j+:8] = ext_data_oe ? ext_data_out[8*j+:8] : 8'hxx;
			mem[key] = tmp;
			bank = act;
			if (wcnt == 0) begin
				gap = idle;
				wbeats++;
			end
		end
		if (!read_strobe_n) begin
			rd_lanes = byte_lane_strobe_n;
			bank = act;
		end
		// lengths follow the strobe so they are final before the bus answers
		if (!write_strobe_n) begin
			wcnt++;
			wr_len = wcnt;
		end else wcnt = 0;
		if (!read_strobe_n) begin
			rcnt++;
			rd_len = rcnt;
		end else rcnt = 0;
		idle = (write_strobe_n && read_strobe_n) ? idle + 1 : 0;
	end
endmodule

// File: test/esc_static_mem_props.sv
// Purpose: pin-level assertions for the static memory controller
// Assumes: hready is tied to hreadyout, one clock domain
// Notes: bound to esc_static_mem from the bench top file
`timescale 1ns/1ps
module esc_static_mem_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] bank_select_out,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [23:0] ext_address_bus,
	input wire logic ext_data_oe
);
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take; // address phase accepted
	logic ext_hit; // region 010 means memory
	assign take = hsel && htrans[1] && hready;
	assign ext_hit = haddr[31:29] == esc_pkg::EXT_REGION;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	ext_stall_a: assert property (take && ext_hit |=> !hreadyout)
		else $error("external access not stalled");
	reg_fast_a: assert property (take && !ext_hit |=> hreadyout)
		else $error("register access stalled");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	strobe_excl_a: assert property (!(!write_strobe_n && !read_strobe_n))
		else $error("both strobes active");
	write_drive_a: assert property (!write_strobe_n |-> ext_data_oe)
		else $error("write without data drive");
	read_float_a: assert property (!read_strobe_n |-> !ext_data_oe)
		else $error("data driven during read");
	addr_hold_a: assert property (!read_strobe_n && $past(read_strobe_n) == 1'b0 |->
		$stable(ext_address_bus) && $stable(bank_select_out))
		else $error("address moved under read strobe");
	strobe_stall_a: assert property (!(write_strobe_n && read_strobe_n) |-> !hreadyout)
		else $error("bus released during strobe");
	beat_gap_a: assert property ($rose(write_strobe_n) |-> !ext_data_oe && read_strobe_n)
		else $error("write beats not separated");
endmodule

// File: test/test_esc_static_mem.sv
// Purpose: self-checking bench for the static memory controller
// Assumes: single AHB-Lite master, memory model on the far side
// Notes: odd banks use active-high selects
`timescale 1ns/1ps
module test_esc_static_mem;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, ext_data_out, ext_data_in, r, a, d, x;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, write_strobe_n, read_strobe_n, ext_data_oe;
	logic [7:0] bank_select_out;
	logic [3:0] byte_lane_strobe_n, rd_lanes;
	logic [23:0] ext_address_bus;
	logic [31:0] seed = 32'h000165ed; // xorshift state
	logic [31:0] emem [int]; // expected memory contents
	esc_pkg::esc_bank_cfg_t cfg [8]; // programmed bank setups
	esc_pkg::esc_bank_cfg_t c;
	int mismatches = 0, compares = 0, bank, wr_len, rd_len, gap, wbeats, b, i, n, sb[4] = '{0, 1, 3, 7};
	always #20 hclk = ~hclk;
	esc_static_mem i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .bank_select_out(bank_select_out), .byte_lane_strobe_n(byte_lane_strobe_n),
		.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .ext_address_bus(ext_address_bus),
		.ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));
	esc_sram_model i_mem (.hclk(hclk), .cs_pol(8'haa), .bank_select_out(bank_select_out),
		.byte_lane_strobe_n(byte_lane_strobe_n), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.ext_address_bus(ext_address_bus), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
		.ext_data_in(ext_data_in), .bank(bank), .wr_len(wr_len), .rd_len(rd_len), .gap(gap), .wbeats(wbeats),
		.rd_lanes(rd_lanes));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one whole-word transfer, waits bounded by the watchdog
	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] rd);
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog: a hung handshake ends the run
	initial begin
		#800000;
		mismatches++;
		final_report;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		bus(0, 32'h0, 0, r); chk(r, 32'h00ff7e);
		bus(0, 32'h4, 0, r); chk(r, 32'h3ff);
		bus(0, 32'h100, 0, r); chk(r, 0);
		for (b = 0; b < 8; b++) begin
			c = '0;
			c.width = (b == 5) ? esc_pkg::WIDTH_8 : (b == 6) ? esc_pkg::WIDTH_16 : esc_pkg::WIDTH_32;
			c.rd_wait = 5'(b);
			c.wr_wait = 5'(b + 1);
			c.turn = 4'(b);
			c.cs_high = b[0];
			c.rd_lanes = b[1];
			c.wr_protect = (b == 2);
			if (b == 4) c.mem_type = esc_pkg::MEM_BURST_ROM;
			c.burst_en = (b == 4);
			cfg[b] = c;
			bus(1, 32'(b * 8), 32'(c), r);
			bus(0, 32'(b * 8), 0, r); chk(r, 32'(c));
		end
		// writes then aliased reads, then a write that must wait out turnaround
		for (i = 0; i < 12; i++) begin
			b = sb[i % 4];
			x = rnd();
			d = rnd();
			a = {3'h2, 3'(b), x[25:24], x[23:2], 2'h0};
			bus(1, a, d, r);
			emem[b * 32'h400000 + int'(x[23:2])] = d;
			chk(bank, b); chk(wr_len, cfg[b].wr_wait + 1);
			a[25:24] = ~a[25:24];
			bus(0, a, 0, r); chk(r, emem[b * 32'h400000 + int'(x[23:2])]);
			chk(rd_len, cfg[b].rd_wait + 1); chk(rd_lanes, cfg[b].rd_lanes ? 4'h0 : 4'hf);
			bus(1, a, d, r); chk(gap >= cfg[b].turn + 1, 1);
		end
		n = wbeats;
		bus(1, 32'h48000010, rnd(), r); chk(wbeats, n);
		bus(0, 32'h40, 0, r); chk(r & 1, 1);
		bus(1, 32'h40, 1, r);
		bus(0, 32'h40, 0, r); chk(r & 1, 0);
		bus(1, 32'h54000020, rnd(), r); chk(wbeats, n + 4);
		bus(1, 32'h58000020, rnd(), r); chk(wbeats, n + 6);
		bus(1, 32'h24, 32'h0c3, r);
		bus(1, 32'h40000000, rnd(), r);
		bus(0, 32'h50000040, 0, r); chk(r, 0); chk(rd_len, 4);
		bus(0, 32'h50000044, 0, r); chk(rd_len, 7);
		n = wbeats;
		bus(1, 32'h50000044, rnd(), r); chk(wbeats, n);
		final_report;
	end
endmodule
bind esc_static_mem esc_static_mem_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .bank_select_out(bank_select_out),
	.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .ext_address_bus(ext_address_bus),
	.ext_data_oe(ext_data_oe));
